// >>> hdl/mxf_feature_ctrl.sv
// What this block does
// (R1) host sets reliability before partitioning; affects user and GP areas
// (R2) capability byte 166 reads 0x05; host-control bit unlocks reliable bits
// (R3) enhanced-reliable-write flag reads 1, the enhanced definition
// (R4) config byte 167 resets 0x1F; bits 4:0 host-writable, 7:5 zero
// (R5) enhanced reliable write is atomic per sector
// (R6) reliable write uses 512-byte units; sector count byte 222 reads 0x01
// (R7) host marks blocks in purge step one; step two purges them
// (R8) purge step two lasts at most 300ms times erase and 0x11 multipliers
// (R9) marked blocks read erased until step two; empty step two idles
// (R10) stop command with bit 0 set preempts the running operation promptly
// (R11) writes, reliable writes, erases and maintenance are preemptible
// (R12) preempt features byte 503 reads 0x03: supported, stop-command based
// (R13) bytes 242..245 count good sectors of last multi-block write
// (R14) partition change timeout byte 199 reads 0x01, in 10ms units
// (R15) interrupt exit timeout byte 198 reads 0x02, bounds busy release
// (R16) preempt management bit 0 resets to 0, host sets it to activate
// (R17) urgent status bit 6 set when maintenance level is 2 or 3
// (R18) maintenance level byte 246 encodes 0 to 3
// (R19) writing trigger byte 164 starts maintenance; completion clears both
// (R20) preempting maintenance clears the trigger byte
// (R21) maintenance support byte 502 reads 1; host enable byte 163 is 0 or 1
module mxf_feature_ctrl
  import mxf_pkg::*;
#(
  parameter int          MS_CYCLES  = CYC_PER_MS,
  parameter int          ERASE_MULT = 1,
  parameter logic [15:0] DEV_ADDR   = 16'h0001,
  parameter logic [7:0]  ERASED_VAL = 8'h00
)(
  // system
  input  wire logic       CLOCK,
  input  wire logic       SYS_RST,
  // mmc link
  input  wire logic       MMC_CLK,
  input  wire logic       MMC_CMD,
  output logic            DAT0_O,
  output logic            DAT0_OE,
  // extended byte read path
  input  wire logic [8:0] EXT_RD_INDEX,
  output logic      [7:0] EXT_RD_DATA,
  // flash core
  input  wire logic       CORE_DONE,
  input  wire logic       CORE_SECTOR_OK,
  input  wire logic       CORE_LEVEL_WE,
  input  wire logic [1:0] CORE_LEVEL,
  output logic            OP_ACTIVE,
  output logic      [2:0] OP_KIND,
  output logic            OP_RELIABLE,
  output logic            OP_STOP,
  output logic            PURGE_MARKED,
  output logic            URGENT_MAINT
);
  localparam int PURGE_LIMIT_MS =
    PURGE_BASE_MS * ERASE_MULT * int'(VAL_PURGE2_MULT);

  typedef struct packed {
    logic        frame;
    logic [5:0]  cnt;
    logic [46:0] shreg;
    mxf_cmd_t    hold;
    logic        tog;
    logic [1:0]  busy_sync;
    logic        dat0_oe;
  } mxf_link_t;

  typedef struct packed {
    logic [2:0]  tog_sync;
    mxf_state_t  state;
    mxf_op_t     kind;
    logic        reliable;
    logic [7:0]  mgmt;
    logic [7:0]  host_en;
    logic [7:0]  trigger;
    logic [7:0]  rel_cfg;
    logic [7:0]  level;
    logic [31:0] good_cnt;
    logic        marked;
    logic [31:0] cyc_cnt;
    logic [31:0] ms_cnt;
    logic [7:0]  rd_data;
    logic        stop;
    logic        busy;
  } mxf_sys_t;

  mxf_link_t lnk_ff, nxt_lnk;
  mxf_sys_t  sys_ff, nxt_sys;

  // link side: deserialise the command line, hand the frame over by toggle
  always_comb
  begin
    nxt_lnk = lnk_ff;
    nxt_lnk.busy_sync = {lnk_ff.busy_sync[0], sys_ff.busy};
    nxt_lnk.dat0_oe   = lnk_ff.busy_sync[1];
    if (!lnk_ff.frame)
    begin
      if (!MMC_CMD)
      begin
        nxt_lnk.frame = 1'b1;
        nxt_lnk.cnt   = 6'h1;
        nxt_lnk.shreg = '0;
      end
    end
    else
    begin
      nxt_lnk.shreg = {lnk_ff.shreg[45:0], MMC_CMD};
      nxt_lnk.cnt   = lnk_ff.cnt + 6'h1;
      if (lnk_ff.cnt == 6'(FRAME_BITS - 1))
      begin
        // crc is not checked here; a bad end bit drops the frame
        nxt_lnk.frame = 1'b0;
        if (MMC_CMD && lnk_ff.shreg[45])
        begin
          nxt_lnk.hold = lnk_ff.shreg[44:7];
          nxt_lnk.tog  = ~lnk_ff.tog;
        end
      end
    end
  end

  always_ff @(posedge MMC_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      lnk_ff <= '0;
    else
      lnk_ff <= nxt_lnk;
  end

  function automatic logic [7:0] ext_byte(
    input logic [8:0] idx,
    input mxf_sys_t   s
  );
    logic [7:0] v;
    v = 8'h00;
    unique case (idx)
      OFS_PREEMPT_MGMT:   v = s.mgmt;
      OFS_MAINT_HOST_EN:  v = s.host_en;
      OFS_WREL_CAP:       v = VAL_WREL_CAP;                       // [R2] [R3]
      OFS_WREL_CFG:       v = s.rel_cfg & CFG_MASK;               // [R4]
      OFS_ERASED_CONT:    v = ERASED_VAL;
      OFS_INT_EXIT_TO:    v = VAL_INT_EXIT_TO;                    // [R15]
      OFS_PART_CHG_TO:    v = VAL_PART_CHG_TO;                    // [R14]
      OFS_REL_SEC_CNT:    v = VAL_REL_SEC_CNT;                    // [R6]
      OFS_GOOD_SEC_LSB:   v = s.good_cnt[7:0];                    // [R13]
      OFS_GOOD_SEC_LSB + 9'h0_001: v = s.good_cnt[15:8];
      OFS_GOOD_SEC_LSB + 9'h0_002: v = s.good_cnt[23:16];
      OFS_GOOD_SEC_LSB + 9'h0_003: v = s.good_cnt[31:24];
      OFS_MAINT_LEVEL:    v = s.level;                            // [R18]
      OFS_MAINT_CAP:      v = VAL_MAINT_CAP;                      // [R21]
      OFS_PREEMPT_FEAT:   v = VAL_PREEMPT_FEAT;                   // [R12]
      default:            v = 8'h00;
    endcase
    return v;
  endfunction : ext_byte

  logic     cmd_new;
  mxf_cmd_t cmd;
  logic [7:0] sw_val;
  logic [7:0] sw_old;
  logic     preempt_ok;

  // the hold word is stable for a whole frame after each toggle
  assign cmd_new = sys_ff.tog_sync[2] ^ sys_ff.tog_sync[1];
  assign cmd     = lnk_ff.hold;

  always_comb
  begin
    sw_old = ext_byte(cmd.arg[16 +: 9] & 9'h0_0FF, sys_ff);
    unique case (cmd.arg[25:24])
      ACC_SET:   sw_val = sw_old | cmd.arg[15:8];
      ACC_CLR:   sw_val = sw_old & ~cmd.arg[15:8];
      default:   sw_val = cmd.arg[15:8];
    endcase
  end

  assign preempt_ok = cmd_new && cmd.index == CMD_STOP && cmd.arg[0]
                   && cmd.arg[31:16] == DEV_ADDR
                   && sys_ff.mgmt[BIT_ACTIVATE]                  // [R16]
                   && sys_ff.state == ST_BUSY;                   // [R11]

  always_comb
  begin
    nxt_sys = sys_ff;
    nxt_sys.tog_sync = {sys_ff.tog_sync[1:0], lnk_ff.tog};
    nxt_sys.rd_data  = ext_byte(EXT_RD_INDEX, sys_ff);
    nxt_sys.stop     = 1'b0;
    if (CORE_LEVEL_WE)
      nxt_sys.level = {6'h00, CORE_LEVEL};                       // [R18]
    unique case (sys_ff.state)
      ST_IDLE:
      begin
        if (cmd_new)
        begin
          if (cmd.index == CMD_SWITCH && cmd.arg[25:24] != 2'h0)
          begin
            unique case (cmd.arg[23:16])
              OFS_PREEMPT_MGMT[7:0]:
                nxt_sys.mgmt = {7'h00, sw_val[BIT_ACTIVATE]};    // [R16]
              OFS_MAINT_HOST_EN[7:0]:
                nxt_sys.host_en = {7'h00, sw_val[0]};            // [R21]
              OFS_WREL_CFG[7:0]:
                if (VAL_WREL_CAP[BIT_HOST_CTRL])
                  nxt_sys.rel_cfg = sw_val & CFG_MASK;           // [R4]
              OFS_MAINT_TRIGGER[7:0]:
                if (sys_ff.host_en[0])
                begin
                  nxt_sys.trigger = sw_val;                      // [R19]
                  nxt_sys.kind    = OP_MAINT;
                  nxt_sys.state   = ST_BUSY;
                end
              default: ;
            endcase
          end
          else if (cmd.index == CMD_WR_ONE || cmd.index == CMD_WR_MULT)
          begin
            nxt_sys.state    = ST_BUSY;
            nxt_sys.kind     = cmd.index == CMD_WR_MULT ? OP_WRITE_MULT
                                                        : OP_WRITE;
            // block length is ignored; units are fixed sectors
            nxt_sys.reliable = cmd.arg[ARG_RELIABLE]
                            && VAL_WREL_CAP[BIT_ENH_REL];        // [R5] [R6]
            if (cmd.index == CMD_WR_MULT)
              nxt_sys.good_cnt = '0;                             // [R13]
          end
          else if (cmd.index == CMD_ERASE)
          begin
            if (cmd.arg == ARG_PURGE1)
              nxt_sys.marked = 1'b1;                             // [R9]
            else if (cmd.arg == ARG_PURGE2)
            begin
              if (sys_ff.marked)
              begin
                nxt_sys.kind  = OP_PURGE;                        // [R9]
                nxt_sys.state = ST_BUSY;
              end
            end
            else
            begin
              nxt_sys.kind  = OP_ERASE;
              nxt_sys.state = ST_BUSY;
            end
          end
          nxt_sys.cyc_cnt = '0;
          nxt_sys.ms_cnt  = '0;
        end
      end
      ST_BUSY:
      begin
        if (sys_ff.cyc_cnt == 32'(MS_CYCLES - 1))
        begin
          nxt_sys.cyc_cnt = '0;
          nxt_sys.ms_cnt  = sys_ff.ms_cnt + 32'h1;
        end
        else
          nxt_sys.cyc_cnt = sys_ff.cyc_cnt + 32'h1;
        if (CORE_SECTOR_OK && sys_ff.kind == OP_WRITE_MULT)
          nxt_sys.good_cnt = sys_ff.good_cnt + 32'h1;            // [R13]
        if (preempt_ok)
        begin
          nxt_sys.stop  = 1'b1;                                  // [R10]
          nxt_sys.state = ST_STOP;
          if (sys_ff.kind == OP_MAINT)
            nxt_sys.trigger = RST_MAINT_TRIGGER;                 // [R20]
        end
        else if (CORE_DONE || (sys_ff.kind == OP_PURGE
                 && sys_ff.ms_cnt >= 32'(PURGE_LIMIT_MS)))      // [R8]
        begin
          nxt_sys.state = ST_STOP;
          if (sys_ff.kind == OP_PURGE)
            nxt_sys.marked = 1'b0;                               // [R9]
          if (sys_ff.kind == OP_MAINT)
          begin
            nxt_sys.trigger = RST_MAINT_TRIGGER;                 // [R19]
            nxt_sys.level   = RST_MAINT_LEVEL;
          end
        end
      end
      ST_STOP:
      begin
        // one settling cycle so busy drops in step with the stop pulse
        nxt_sys.state    = ST_IDLE;
        nxt_sys.kind     = OP_NONE;
        nxt_sys.reliable = 1'b0;
      end
      default:
        nxt_sys.state = ST_IDLE;
    endcase
    nxt_sys.busy = nxt_sys.state == ST_BUSY;
  end

  always_ff @(posedge CLOCK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      sys_ff         <= '0;
      sys_ff.mgmt    <= RST_PREEMPT_MGMT;
      sys_ff.host_en <= RST_MAINT_HOST_EN;
      sys_ff.trigger <= RST_MAINT_TRIGGER;
      sys_ff.rel_cfg <= RST_WREL_CFG;
      sys_ff.level   <= RST_MAINT_LEVEL;
      sys_ff.state   <= ST_IDLE;
      sys_ff.kind    <= OP_NONE;
    end
    else
      sys_ff <= nxt_sys;
  end

  // busy on data line 0 is driven low by the device
  assign DAT0_O       = 1'b0;
  assign DAT0_OE      = lnk_ff.dat0_oe;
  assign EXT_RD_DATA  = sys_ff.rd_data;
  assign OP_ACTIVE    = sys_ff.busy;
  assign OP_KIND      = sys_ff.kind;
  assign OP_RELIABLE  = sys_ff.reliable;                         // [R5]
  assign OP_STOP      = sys_ff.stop;
  assign PURGE_MARKED = sys_ff.marked;                           // [R9]
  assign URGENT_MAINT = sys_ff.level[1];                         // [R17]

  // checks
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (SYS_RST);

  AST_CAP_READ: assert property (                                 // [R2]
    EXT_RD_INDEX == OFS_WREL_CAP |=> EXT_RD_DATA == 8'h05)
    else $error("capability byte wrong");

  AST_CFG_RSVD: assert property (                                 // [R4]
    EXT_RD_INDEX == OFS_WREL_CFG |=> EXT_RD_DATA[7:5] == 3'h0)
    else $error("reserved config bits set");

  AST_FEAT_READ: assert property (                                // [R12]
    EXT_RD_INDEX == OFS_PREEMPT_FEAT |=> EXT_RD_DATA == 8'h03)
    else $error("preempt features wrong");

  AST_GOOD_COUNT: assert property (                               // [R13]
    sys_ff.state == ST_BUSY && sys_ff.kind == OP_WRITE_MULT
    && CORE_SECTOR_OK && !preempt_ok
    |=> sys_ff.good_cnt == $past(sys_ff.good_cnt) + 32'h1)
    else $error("good sector count did not advance");

  AST_PREEMPT: assert property (                                  // [R10]
    preempt_ok |=> OP_STOP && !OP_ACTIVE ##1 sys_ff.state == ST_IDLE)
    else $error("preempt not honoured");

  AST_PREEMPT_MAINT: assert property (                            // [R20]
    preempt_ok && sys_ff.kind == OP_MAINT |=> sys_ff.trigger == 8'h00)
    else $error("trigger kept after preempt");

  AST_MAINT_DONE: assert property (                               // [R19]
    sys_ff.state == ST_BUSY && sys_ff.kind == OP_MAINT && CORE_DONE
    && !preempt_ok |=> sys_ff.trigger == 8'h00 && sys_ff.level == 8'h00)
    else $error("maintenance completion left bytes set");

  AST_URGENT: assert property (                                   // [R17]
    CORE_LEVEL_WE && !(sys_ff.state == ST_BUSY && sys_ff.kind == OP_MAINT
    && CORE_DONE && !preempt_ok)
    |=> URGENT_MAINT == ($past(CORE_LEVEL) >= 2'h2))
    else $error("urgent flag mismatch");

  AST_PURGE_EMPTY: assert property (                              // [R9]
    cmd_new && sys_ff.state == ST_IDLE && cmd.index == CMD_ERASE
    && cmd.arg == ARG_PURGE2 && !sys_ff.marked
    |=> sys_ff.state == ST_IDLE)
    else $error("empty purge step two ran");

  AST_PURGE_LIMIT: assert property (                              // [R8]
    sys_ff.kind == OP_PURGE && sys_ff.state == ST_BUSY
    |-> sys_ff.ms_cnt <= 32'(PURGE_LIMIT_MS))
    else $error("purge step two overran");

  AST_MGMT_LOCK: assert property (                                // [R16]
    $rose(sys_ff.mgmt[0]) |-> $past(cmd_new))
    else $error("preempt activated without switch");
endmodule : mxf_feature_ctrl

// >>> hdl/mxf_pkg.sv
package mxf_pkg;
  // extended byte offsets
  localparam logic [8:0] OFS_PREEMPT_MGMT  = 9'h0_0A1;
  localparam logic [8:0] OFS_MAINT_HOST_EN = 9'h0_0A3;
  localparam logic [8:0] OFS_MAINT_TRIGGER = 9'h0_0A4;
  localparam logic [8:0] OFS_WREL_CAP      = 9'h0_0A6;
  localparam logic [8:0] OFS_WREL_CFG      = 9'h0_0A7;
  localparam logic [8:0] OFS_ERASED_CONT   = 9'h0_0B5;
  localparam logic [8:0] OFS_INT_EXIT_TO   = 9'h0_0C6;
  localparam logic [8:0] OFS_PART_CHG_TO   = 9'h0_0C7;
  localparam logic [8:0] OFS_REL_SEC_CNT   = 9'h0_0DE;
  localparam logic [8:0] OFS_GOOD_SEC_LSB  = 9'h0_0F2;
  localparam logic [8:0] OFS_MAINT_LEVEL   = 9'h0_0F6;
  localparam logic [8:0] OFS_MAINT_CAP     = 9'h0_1F6;
  localparam logic [8:0] OFS_PREEMPT_FEAT  = 9'h0_1F7;
  // reset and fixed values
  localparam logic [7:0] RST_PREEMPT_MGMT  = 8'h00;
  localparam logic [7:0] RST_MAINT_HOST_EN = 8'h00;
  localparam logic [7:0] RST_MAINT_TRIGGER = 8'h00;
  localparam logic [7:0] VAL_WREL_CAP      = 8'h05;
  localparam logic [7:0] RST_WREL_CFG      = 8'h1F;
  localparam logic [7:0] VAL_INT_EXIT_TO   = 8'h02;
  localparam logic [7:0] VAL_PART_CHG_TO   = 8'h01;
  localparam logic [7:0] VAL_REL_SEC_CNT   = 8'h01;
  localparam logic [7:0] RST_MAINT_LEVEL   = 8'h00;
  localparam logic [7:0] VAL_MAINT_CAP     = 8'h01;
  localparam logic [7:0] VAL_PREEMPT_FEAT  = 8'h03;
  localparam logic [7:0] VAL_PURGE2_MULT   = 8'h11;
  // field positions
  localparam int BIT_HOST_CTRL   = 0;
  localparam int BIT_ENH_REL     = 2;
  localparam int BIT_ACTIVATE    = 0;
  localparam int BIT_URGENT      = 6;
  localparam int CFG_BITS        = 5;
  localparam logic [7:0] CFG_MASK = 8'h1F;
  // command indices and arguments
  localparam logic [5:0] CMD_SWITCH  = 6'h06;
  localparam logic [5:0] CMD_STOP    = 6'h0C;
  localparam logic [5:0] CMD_WR_ONE  = 6'h18;
  localparam logic [5:0] CMD_WR_MULT = 6'h19;
  localparam logic [5:0] CMD_ERASE   = 6'h26;
  localparam logic [1:0] ACC_SET     = 2'h1;
  localparam logic [1:0] ACC_CLR     = 2'h2;
  localparam logic [1:0] ACC_WRITE   = 2'h3;
  localparam logic [31:0] ARG_PURGE1 = 32'h8000_0001;
  localparam logic [31:0] ARG_PURGE2 = 32'h8000_8000;
  localparam int ARG_RELIABLE = 31;
  localparam int SECTOR_BYTES = 512;
  localparam int FRAME_BITS   = 48;
  // timing
  localparam int CLK_HZ          = 40_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int PURGE_BASE_MS   = 300;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_STOP = 2'b11
  } mxf_state_t;

  typedef enum logic [2:0] {
    OP_NONE, OP_WRITE, OP_WRITE_MULT, OP_ERASE, OP_PURGE, OP_MAINT
  } mxf_op_t;

  typedef struct packed {
    logic [5:0]  index;
    logic [31:0] arg;
  } mxf_cmd_t;
endpackage : mxf_pkg

// >>> test/mxf_host_model.sv
module mxf_host_model (
  // link toward the device
  output logic MMC_CLK,
  output logic MMC_CMD
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    MMC_CLK = 1'b0;
    MMC_CMD = 1'b1;
  end

  // the clock only runs when ticked: inside a frame, its short busy tail, and around reset
  task automatic tick(input int n);
    repeat (n)
    begin
      #3 MMC_CLK = 1'b1;
      #3 MMC_CLK = 1'b0;
    end
  endtask : tick

  // crc left zero: the device does not check it
  task automatic send_cmd(input logic [5:0] idx, input logic [31:0] arg);
    logic [47:0] frame;
    frame = {1'b0, 1'b1, idx, arg, 7'h00, 1'b1};
    for (int i = 47; i >= 0; i--)
    begin
      MMC_CMD = frame[i];
      tick(1);
    end
    MMC_CMD = 1'b1;
    // long enough for busy to reach the data line through the sync
    tick(30);
  endtask : send_cmd
endmodule : mxf_host_model

// >>> test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mxf_pkg::*;

  localparam int MSC = 4;
  localparam int LIM = PURGE_BASE_MS * int'(VAL_PURGE2_MULT) * MSC;

  logic       clock = 1'b0;
  logic       sys_rst = 1'b1;
  logic       core_done = 1'b0;
  logic       core_sector_ok = 1'b0;
  logic       core_level_we = 1'b0;
  logic [1:0] core_level = 2'h0;
  logic [8:0] ext_rd_index = 9'h000;
  wire logic  mmc_clk, mmc_cmd, dat0_o, dat0_oe, op_active, op_reliable;
  wire logic  op_stop, purge_marked, urgent_maint;
  wire logic [7:0] ext_rd_data;
  wire logic [2:0] op_kind;
  int         errors, compares, stops, n;

  logic [8:0] ro_ofs [14] = '{9'h0A1, 9'h0A3, 9'h0A6, 9'h0A7, 9'h0C6,
    9'h0C7, 9'h0DE, 9'h0F2, 9'h0F3, 9'h0F4, 9'h0F5, 9'h0F6, 9'h1F6, 9'h1F7};
  logic [7:0] ro_val [14] = '{8'h00, 8'h00, 8'h05, 8'h1F, 8'h02, 8'h01,
    8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03};
  logic [5:0]  op_idx [4] = '{CMD_WR_ONE, CMD_WR_MULT, CMD_WR_MULT, CMD_ERASE};
  logic [31:0] op_arg [4] = '{32'h0000_0000, 32'h0000_0000, 32'h8000_0000,
    32'h0000_0000};
  logic [7:0]  op_knd [4] = '{8'h01, 8'h02, 8'h02, 8'h03};

  always #12.5 clock = ~clock;

  always @(posedge clock)
    if (op_stop === 1'b1)
      stops++;

  mxf_feature_ctrl #(.MS_CYCLES(MSC), .ERASE_MULT(1)) mxf_feature_ctrl_inst (
    .CLOCK(clock), .SYS_RST(sys_rst), .MMC_CLK(mmc_clk), .MMC_CMD(mmc_cmd),
    .DAT0_O(dat0_o), .DAT0_OE(dat0_oe), .EXT_RD_INDEX(ext_rd_index),
    .EXT_RD_DATA(ext_rd_data), .CORE_DONE(core_done),
    .CORE_SECTOR_OK(core_sector_ok), .CORE_LEVEL_WE(core_level_we),
    .CORE_LEVEL(core_level), .OP_ACTIVE(op_active), .OP_KIND(op_kind),
    .OP_RELIABLE(op_reliable), .OP_STOP(op_stop),
    .PURGE_MARKED(purge_marked), .URGENT_MAINT(urgent_maint));

  mxf_host_model mxf_host_model_inst (.MMC_CLK(mmc_clk), .MMC_CMD(mmc_cmd));

  task automatic stop_test;
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [8:0] ofs, input logic [7:0] exp);
    @(posedge clock) ext_rd_index <= ofs;
    @(posedge clock) #1 check(ext_rd_data, exp);
  endtask : rd

  // leaves ample time for the crossing before anything is looked at
  task automatic cmd(input logic [5:0] idx, input logic [31:0] arg);
    @(posedge clock) #2 mxf_host_model_inst.send_cmd(idx, arg);
    repeat (8) @(posedge clock);
    #1;
  endtask : cmd

  task automatic sw(input logic [1:0] acc, input logic [8:0] ofs,
                    input logic [7:0] val);
    cmd(CMD_SWITCH, {6'h00, acc, ofs[7:0], val, 8'h00});
  endtask : sw

  // m is {done, sector ok, level load}
  task automatic pulse(input logic [2:0] m, input logic [1:0] lvl);
    @(posedge clock)
    begin
      {core_done, core_sector_ok, core_level_we} <= m;
      core_level <= lvl;
    end
    @(posedge clock) {core_done, core_sector_ok, core_level_we} <= 3'h0;
    @(posedge clock) #1;
  endtask : pulse

  task automatic stop_ok;
    n = stops;
    cmd(CMD_STOP, 32'h0001_0001);
    check(8'(op_active), 8'h00);
    check(8'(stops - n), 8'h01);
  endtask : stop_ok

  initial
  begin
    #2_000_000;
    errors++;
    stop_test();
  end

  initial
  begin
    mxf_host_model_inst.tick(4);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    foreach (ro_ofs[i])
      rd(ro_ofs[i], ro_val[i]);
    sw(ACC_WRITE, OFS_WREL_CAP, 8'h00);
    rd(OFS_WREL_CAP, 8'h05);
    sw(ACC_WRITE, OFS_WREL_CFG, 8'hEA);
    rd(OFS_WREL_CFG, 8'h0A);
    sw(ACC_CLR, OFS_WREL_CFG, 8'h02);
    rd(OFS_WREL_CFG, 8'h08);
    sw(ACC_SET, OFS_WREL_CFG, 8'h01);
    rd(OFS_WREL_CFG, 8'h09);
    // preempt without activation must leave the write running
    cmd(CMD_WR_ONE, 32'h0000_0000);
    cmd(CMD_STOP, 32'h0001_0001);
    check(8'(op_active), 8'h01);
    check(8'(stops), 8'h00);
    pulse(3'h4, 2'h0);
    check(8'(op_active), 8'h00);
    sw(ACC_WRITE, OFS_PREEMPT_MGMT, 8'h01);
    rd(OFS_PREEMPT_MGMT, 8'h01);
    for (int i = 0; i < 4; i++)
    begin
      cmd(op_idx[i], op_arg[i]);
      check(8'(op_active), 8'h01);
      check(8'(op_kind), op_knd[i]);
      check(8'(op_reliable), 8'(i == 2));
      check(8'({dat0_oe, dat0_o}), 8'h02);
      if (i == 0)
      begin
        cmd(CMD_STOP, 32'h0002_0001);
        cmd(CMD_STOP, 32'h0001_0000);
        check(8'(op_active), 8'h01);
      end
      stop_ok();
      check(8'(dat0_oe), 8'h00);
    end
    // 260 sectors puts a carry into the second byte
    cmd(CMD_WR_MULT, 32'h0000_0000);
    repeat (260) pulse(3'h2, 2'h0);
    pulse(3'h4, 2'h0);
    rd(OFS_GOOD_SEC_LSB, 8'h04);
    rd(OFS_GOOD_SEC_LSB + 9'h001, 8'h01);
    rd(OFS_GOOD_SEC_LSB + 9'h002, 8'h00);
    rd(OFS_GOOD_SEC_LSB + 9'h003, 8'h00);
    cmd(CMD_ERASE, ARG_PURGE2);
    check(8'(op_active), 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      cmd(CMD_ERASE, ARG_PURGE1);
      if (op_active === 1'b1)
        pulse(3'h4, 2'h0);
      check(8'(purge_marked), 8'h01);
      cmd(CMD_ERASE, ARG_PURGE2);
      check(8'(op_kind), 8'h04);
      if (k == 0)
        pulse(3'h4, 2'h0);
      else if (k == 1)
        stop_ok();
      else
      begin
        repeat (LIM - 100) @(posedge clock);
        check(8'(op_active), 8'h01);
        repeat (200) @(posedge clock);
      end
      check(8'(op_active), 8'h00);
      if (k != 1)
        check(8'(purge_marked), 8'h00);
    end
    sw(ACC_WRITE, OFS_MAINT_TRIGGER, 8'h5A);
    check(8'(op_active), 8'h00);
    for (int l = 0; l < 4; l++)
    begin
      pulse(3'h1, 2'(l));
      rd(OFS_MAINT_LEVEL, 8'(l));
      check(8'(urgent_maint), 8'(l >= 2));
    end
    sw(ACC_WRITE, OFS_MAINT_HOST_EN, 8'h01);
    rd(OFS_MAINT_HOST_EN, 8'h01);
    sw(ACC_WRITE, OFS_MAINT_TRIGGER, 8'h5A);
    check(8'(op_kind), 8'h05);
    pulse(3'h4, 2'h0);
    check(8'({op_active, urgent_maint}), 8'h00);
    rd(OFS_MAINT_LEVEL, 8'h00);
    pulse(3'h1, 2'h3);
    sw(ACC_WRITE, OFS_MAINT_TRIGGER, 8'h01);
    check(8'(op_active), 8'h01);
    stop_ok();
    // a second reset must bring the writable bytes back
    @(posedge clock) sys_rst <= 1'b1;
    mxf_host_model_inst.tick(4);
    @(posedge clock) sys_rst <= 1'b0;
    rd(OFS_PREEMPT_MGMT, 8'h00);
    rd(OFS_MAINT_HOST_EN, 8'h00);
    rd(OFS_WREL_CFG, 8'h1F);
    stop_test();
  end
endmodule : tb
